/* hw/dwsl_regs.vh */
// Purpose: Constants for the dual wiper serial loader
// Assumes: Included by hw/dwsl_loader.v
// Notes: Word layout, reset values and widths
`ifndef DWSL_REGS_VH
`define DWSL_REGS_VH
`define DWSL_WORD_W 9
`define DWSL_CODE_W 8
`define DWSL_CHAN_BIT 8
`define DWSL_CODE_MSB 7
`define DWSL_CODE_LSB 0
`define DWSL_MIDSCALE 8'h80
`define DWSL_SHIFT_RST 9'h000
`define DWSL_CHAN_FIRST 1'b0
`define DWSL_TAPS 256
`define DWSL_SCLK_IDLE 1'b0
`define DWSL_SDI_IDLE 1'b0
`define DWSL_CS_IDLE 1'b1
`endif

/* hw/dwsl_loader.v */
// Purpose: Serial loader for a two channel, 256 position wiper pair
// Assumes: Serial clock, data and chip select are asynchronous pins sampled on CLK_I
// Notes: Power-on reset is the only reset; wiper codes drive the tap decoders
`timescale 1ns/1ps
`include "dwsl_regs.vh"
module dwsl_loader #(
  parameter WORD_W = `DWSL_WORD_W,
  parameter CODE_W = `DWSL_CODE_W,
  parameter TAPS = `DWSL_TAPS
) (
  // Clock and power-on reset
  input wire CLK_I,
  input wire RST_N_I,
  // Serial pins
  input wire SCLK_I,
  input wire SERIAL_DATA_IN_I,
  input wire CS_N_I,
  // Wiper codes toward the tap decoders
  output wire [CODE_W-1:0] WIPER1_CODE_O,
  output wire [CODE_W-1:0] WIPER2_CODE_O,
  // One-hot tap selects, bit 0 at the B end
  output wire [TAPS-1:0] WIPER1_TAP_O,
  output wire [TAPS-1:0] WIPER2_TAP_O,
  // One-cycle pulse as a wiper is loaded
  output wire UPDATE_O
);

  wire sclk_rise;
  wire sdi_s;
  wire cs_n_s;
  wire cs_rise;
  wire cs_low;
  reg [WORD_W-1:0] shift_q;
  reg [WORD_W-1:0] shift_d;
  reg [CODE_W-1:0] wiper1_q;
  reg [CODE_W-1:0] wiper1_d;
  reg [CODE_W-1:0] wiper2_q;
  reg [CODE_W-1:0] wiper2_d;
  reg update_q;

  // Serial clock: only its rising edge counts; clean edges assumed
  dwsl_sync #(
    .RST_LEVEL(`DWSL_SCLK_IDLE)
  ) u_sclk_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i(SCLK_I),
    .level_o(),
    .rise_o(sclk_rise)
  );

  // Serial data: level only, aligned with the clock edge detector
  dwsl_sync #(
    .RST_LEVEL(`DWSL_SDI_IDLE)
  ) u_sdi_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i(SERIAL_DATA_IN_I),
    .level_o(sdi_s),
    .rise_o()
  );

  // Chip select resets high so a select held high across reset loads nothing
  dwsl_sync #(
    .RST_LEVEL(`DWSL_CS_IDLE)
  ) u_cs_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i(CS_N_I),
    .level_o(cs_n_s),
    .rise_o(cs_rise)
  );

  assign cs_low = ~cs_n_s;

  always @* begin
    shift_d = shift_q;
    if (sclk_rise && cs_low) begin
      // Older bits fall off the top, keeping the last nine
      shift_d = {shift_q[WORD_W-2:0], sdi_s};
    end
  end

  always @* begin
    wiper1_d = wiper1_q;
    wiper2_d = wiper2_q;
    if (cs_rise) begin
      // Channel bit picks the target; the other wiper holds
      if (shift_q[`DWSL_CHAN_BIT] == `DWSL_CHAN_FIRST) begin
        wiper1_d = shift_q[`DWSL_CODE_MSB:`DWSL_CODE_LSB];
      end else begin
        wiper2_d = shift_q[`DWSL_CODE_MSB:`DWSL_CODE_LSB];
      end
    end
  end

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      shift_q <= `DWSL_SHIFT_RST;
      wiper1_q <= `DWSL_MIDSCALE;
      wiper2_q <= `DWSL_MIDSCALE;
      update_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      wiper1_q <= wiper1_d;
      wiper2_q <= wiper2_d;
      update_q <= cs_rise;
    end
  end

  assign WIPER1_CODE_O = wiper1_q;
  assign WIPER2_CODE_O = wiper2_q;
  assign UPDATE_O = update_q;

  // Tap selects are registered from the next code, so they move with it
  dwsl_tap_dec #(
    .CODE_W(CODE_W),
    .TAPS(TAPS)
  ) u_tap1 (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .code_i(wiper1_d),
    .tap_o(WIPER1_TAP_O)
  );

  dwsl_tap_dec #(
    .CODE_W(CODE_W),
    .TAPS(TAPS)
  ) u_tap2 (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .code_i(wiper2_d),
    .tap_o(WIPER2_TAP_O)
  );

endmodule // dwsl_loader

// Two flip-flops against metastability, a third only to find rising edges
module dwsl_sync #(
  parameter [0:0] RST_LEVEL = 1'b0
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Asynchronous pin
  input wire pin_i,
  // Synchronised level and its rising edge
  output wire level_o,
  output wire rise_o
);

  reg meta_q;
  reg level_q;
  reg prev_q;

  // Reset to the pin's idle level so release shows no false edge
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_LEVEL;
      level_q <= RST_LEVEL;
      prev_q <= RST_LEVEL;
    end else begin
      meta_q <= pin_i;
      level_q <= meta_q;
      prev_q <= level_q;
    end
  end

  assign level_o = level_q;
  assign rise_o = level_q & ~prev_q;

endmodule // dwsl_sync

// One-hot tap select: code 0 is the B end, code N selects tap N
module dwsl_tap_dec #(
  parameter CODE_W = `DWSL_CODE_W,
  parameter TAPS = `DWSL_TAPS
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Code that the wiper register takes at the next edge
  input wire [CODE_W-1:0] code_i,
  // Registered tap select
  output wire [TAPS-1:0] tap_o
);

  reg [TAPS-1:0] tap_q;
  reg [TAPS-1:0] tap_d;

  always @* begin
    tap_d = {{(TAPS-1){1'b0}}, 1'b1} << code_i;
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap_q <= {{(TAPS-1){1'b0}}, 1'b1} << `DWSL_MIDSCALE;
    end else begin
      tap_q <= tap_d;
    end
  end

  assign tap_o = tap_q;

endmodule // dwsl_tap_dec

/* sim/dwsl_properties.sv */
// Purpose: loader port checks. Assumes: top ports only. Notes: bound below
`timescale 1ns/1ps
module dwsl_props #(parameter CODE_W = 8, parameter TAPS = 256) (
  // Clock and reset
  input wire CLK_I,
  input wire RST_N_I,
  // Serial pins
  input wire SCLK_I,
  input wire SERIAL_DATA_IN_I,
  input wire CS_N_I,
  // Outputs
  input wire UPDATE_O,
  input wire [CODE_W-1:0] WIPER1_CODE_O,
  input wire [CODE_W-1:0] WIPER2_CODE_O,
  input wire [TAPS-1:0] WIPER1_TAP_O,
  input wire [TAPS-1:0] WIPER2_TAP_O);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence cs_idle; CS_N_I [*6]; endsequence
  AST_PULSE: assert property (UPDATE_O |=> !UPDATE_O) else $error("pulse");
  AST_LD1: assert property ($changed(WIPER1_CODE_O) |-> UPDATE_O) else $error("ld1");
  AST_LD2: assert property ($changed(WIPER2_CODE_O) |-> UPDATE_O) else $error("ld2");
  AST_ONE: assert property (!($changed(WIPER1_CODE_O) && $changed(WIPER2_CODE_O)))
    else $error("both");
  AST_TAP1: assert property (WIPER1_TAP_O == 256'h1 << WIPER1_CODE_O) else $error("t1");
  AST_TAP2: assert property (WIPER2_TAP_O == 256'h1 << WIPER2_CODE_O) else $error("t2");
  AST_IDLE: assert property (cs_idle |=> $stable({WIPER1_CODE_O, WIPER2_CODE_O}))
    else $error("idle");
  AST_ANS: assert property ($rose(CS_N_I) |-> ##[2:6] UPDATE_O) else $error("ans");
  AST_CSHI: assert property (UPDATE_O |-> $past(CS_N_I, 3)) else $error("cs");
endmodule // dwsl_props
bind dwsl_loader dwsl_props #(.CODE_W(CODE_W), .TAPS(TAPS)) u_props (.CLK_I(CLK_I),
  .RST_N_I(RST_N_I), .SCLK_I(SCLK_I), .SERIAL_DATA_IN_I(SERIAL_DATA_IN_I), .CS_N_I(CS_N_I),
  .UPDATE_O(UPDATE_O), .WIPER1_CODE_O(WIPER1_CODE_O), .WIPER2_CODE_O(WIPER2_CODE_O),
  .WIPER1_TAP_O(WIPER1_TAP_O), .WIPER2_TAP_O(WIPER2_TAP_O));

/* sim/dwsl_master.sv */
// Purpose: serial master model. Assumes: 160 ns link clock. Notes: clock idles low
`timescale 1ns/1ps
module dwsl_master (
  // Serial pins
  output logic sclk_o = 1'b0,
  output logic sdi_o = 1'b0,
  output logic cs_n_o = 1'b1);
  task send(input [15:0] w, input int n);
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = w[i];
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    #80 cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask
endmodule // dwsl_master

/* sim/tb_top.sv */
// Purpose: loader bench. Assumes: 50 MHz clock. Notes: checker bound
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
  logic clk = 0, rst_n = 0, upd;
  wire sclk, serial_data_in, cs_n;
  wire [7:0] w1, w2;
  wire [255:0] t1, t2;
  int mismatches = 0, checks_done = 0;
  always #10 clk = ~clk;
  dwsl_master m (.sclk_o(sclk), .sdi_o(serial_data_in), .cs_n_o(cs_n));
  dwsl_loader dut (.CLK_I(clk), .RST_N_I(rst_n), .SCLK_I(sclk), .SERIAL_DATA_IN_I(serial_data_in),
    .CS_N_I(cs_n), .WIPER1_CODE_O(w1), .WIPER2_CODE_O(w2), .WIPER1_TAP_O(t1),
    .WIPER2_TAP_O(t2), .UPDATE_O(upd));
  task stop_test;
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task load(input [15:0] w, input int n, input [7:0] e1, input [7:0] e2);
    int k;
    @(negedge clk);
    m.send(w, n);
    for (k = 0; k < 20 && upd !== 1'b1; k++) @(negedge clk);
    if (k == 20) begin
      mismatches++;
      stop_test;
    end else begin
      `CHK(w1, e1)
      `CHK(w2, e2)
    end
  endtask
  task t_reset; `CHK({w1, w2, t1[128]}, 17'h10101) endtask
  task t_route;
    load(16'h0000, 9, 8'h00, 8'h80);
    `CHK(t1, 256'h1)
    load(16'h01a5, 9, 8'h00, 8'ha5);
    `CHK(t2, 256'h1 << 8'ha5)
  endtask
  task t_extra; load(16'h0b3c, 12, 8'h00, 8'h3c); endtask
  task t_power;
    rst_n = 0;
    @(negedge clk);
    `CHK({w1, w2}, 16'h8080)
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    t_reset; t_route; t_extra; t_power;
    stop_test;
  end
endmodule // tb_top
